// ### design/gcd_pkg.sv
// Purpose: shared constants and types for the port C / port D data register block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes: printed offsets are register indices; byte address is four times the index
//
// Functional notes
// - port C data register is 8 bits read/write, bit k is pin k latch.
// - mode code 00 alternate, 01 output, 10 input pull-up, 11 input no pull-up.
// - port C read in output or alternate mode returns the latch bit.
// - any pin in an input mode reads its sampled pin level.
// - in output mode a write updates the latch and drives the pin.
// - in alternate or input modes a write updates only the latch, pin unchanged.
// - power-on reset clears port C to zero, pins start as input with pull-up.
// - both registers keep contents through standby, sleep and manual reset.
// - port D has six read/write bits (7,5,3,2,1,0) and read-only bits 6, 4.
// - power-on reset clears port D writable bits, pins start input with pull-up.
// - port D writable bits read the latch in output or alternate mode.
// - port D bits 6 and 4 read zero unless in an input mode.
// - writes to port D bits 4 and 6 are always discarded.
// - each pin's pull-up is enabled only through mode code 10, input pull-up.
package gcd_pkg;
  localparam int unsigned GCD_PORT_W = 8;
  localparam int unsigned GCD_MODE_W = 2 * GCD_PORT_W;
  // register indices; byte address is index times four
  localparam logic [31:0] GCD_PORT_C_IDX = 32'h0400_0124;
  localparam logic [31:0] GCD_PORT_D_IDX = 32'h0400_0126;
  localparam logic [31:0] GCD_MODE_C_IDX = 32'h0400_0140;
  localparam logic [31:0] GCD_MODE_D_IDX = 32'h0400_0141;
  localparam logic [7:0] GCD_PORT_C_RW = 8'hFF;
  localparam logic [7:0] GCD_PORT_D_RW = 8'hAF;
  localparam logic [7:0] GCD_DATA_RST = 8'h00;
  localparam logic [15:0] GCD_MODE_RST = 16'hAAAA;
  localparam logic [1:0] GCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] GCD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {GCD_MODE_ALT, GCD_MODE_OUT, GCD_MODE_IN_PU, GCD_MODE_IN_NOPU} gcd_mode_t;

  function automatic logic [31:0] gcd_byte_addr(input logic [31:0] idx);
    gcd_byte_addr = {idx[29:0], 2'b00};
  endfunction
endpackage

// ### design/gcd_bank_if.sv
// Purpose: carrier between the register front end and one pin bank
// Assumes: single clock domain
// Notes: rd_data is combinational, the pin outputs are registered in the bank
`timescale 1ns/1ns
interface gcd_bank_if #(parameter int unsigned W = 8);
  logic [2*W-1:0] mode;
  logic wr_en;
  logic [W-1:0] wr_data;
  logic [W-1:0] rd_data;
  logic [W-1:0] pin_o;
  logic [W-1:0] pin_oe;
  logic [W-1:0] pull_en;
  modport bank (input mode, input wr_en, input wr_data, output rd_data, output pin_o, output pin_oe,
                output pull_en);
  modport ctrl (output mode, output wr_en, output wr_data, input rd_data, input pin_o, input pin_oe,
                input pull_en);
endinterface

// ### design/gcd_pin_bank.sv
// Purpose: one port's data latch, pin synchroniser, read selection and pin drive
// Assumes: mode vector holds two bits per pin, pin k at bits 2k+1:2k
// Notes: RW_MASK marks writable pins; other pins are input-only
`timescale 1ns/1ns
module gcd_pin_bank
  import gcd_pkg::*;
#(
  parameter int unsigned W = GCD_PORT_W,
  parameter logic [GCD_PORT_W-1:0] RW_MASK = GCD_PORT_C_RW
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] pin_i,
  gcd_bank_if.bank bus
);
  if (W != GCD_PORT_W)
  begin : g_bad_width
    $error("gcd_pin_bank: W must equal the port width");
  end

  logic [W-1:0] pin_s1_r;
  logic [W-1:0] pin_s2_r;
  logic [W-1:0] latch_r;
  logic [W-1:0] latch_nxt;
  logic [W-1:0] pin_o_r;
  logic [W-1:0] pin_oe_r;
  logic [W-1:0] pull_en_r;
  wire [W-1:0] in_mask;
  wire [W-1:0] out_mask;
  wire [W-1:0] pu_mask;

  function automatic logic [W-1:0] mode_mask(input logic [2*W-1:0] mode, input gcd_mode_t code);
    logic [W-1:0] m;
    m = '0;
    for (int k = 0; k < W; k++)
    begin
      m[k] = (gcd_mode_t'(mode[2*k +: 2]) == code);
    end
    mode_mask = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign in_mask = mode_mask(bus.mode, GCD_MODE_IN_PU) | mode_mask(bus.mode, GCD_MODE_IN_NOPU);
  assign out_mask = mode_mask(bus.mode, GCD_MODE_OUT) & RW_MASK;
  assign pu_mask = mode_mask(bus.mode, GCD_MODE_IN_PU);

  ////////////////////////////////////////////////////////////////////////////
  // read selection: input modes see the pin, else latch, input-only pins else 0
  assign bus.rd_data = (in_mask & pin_s2_r) | (~in_mask & RW_MASK & latch_r);

  // read-only bits never store anything
  assign latch_nxt = bus.wr_en ? ((latch_r & ~RW_MASK) | (bus.wr_data & RW_MASK)) : latch_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    pin_s1_r <= pin_i;
    pin_s2_r <= pin_s1_r;
  end

  // only power-on reset touches the latch; low power and manual reset have no input here
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      latch_r <= GCD_DATA_RST;
    end
    else
    begin
      latch_r <= latch_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_o_r <= GCD_DATA_RST;
      pin_oe_r <= '0;
      pull_en_r <= '1;
    end
    else
    begin
      pin_o_r <= latch_r;
      pin_oe_r <= out_mask;
      pull_en_r <= pu_mask;
    end
  end

  assign bus.pin_o = pin_o_r;
  assign bus.pin_oe = pin_oe_r;
  assign bus.pull_en = pull_en_r;

  ////////////////////////////////////////////////////////////////////////////
  property p_rd_pin;
    @(posedge sys_clk) disable iff (reset)
    ((bus.rd_data ^ $past(pin_i, 2)) & in_mask) == '0;
  endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("input-mode read not the pin level");

  property p_rd_latch;
    @(posedge sys_clk) disable iff (reset)
    bus.wr_en |=> ((bus.rd_data ^ $past(bus.wr_data)) & ~in_mask & RW_MASK) == '0;
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("non-input read not the written latch");

  property p_ro_zero;
    @(posedge sys_clk) disable iff (reset)
    (bus.rd_data & ~in_mask & ~RW_MASK) == '0;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("input-only bit not low outside input");

  property p_ro_discard;
    @(posedge sys_clk) disable iff (reset)
    bus.wr_en |=> (latch_r & ~RW_MASK) == '0;
  endproperty
  a_ro_discard: assert property (p_ro_discard) else $error("write stored into input-only bit");

  property p_hold;
    @(posedge sys_clk) disable iff (reset)
    !bus.wr_en |=> $stable(latch_r);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without a write");

  property p_drive;
    @(posedge sys_clk) disable iff (reset)
    bus.wr_en && $stable(bus.mode) ##1 $stable(bus.mode) |=>
      ((bus.pin_o ^ $past(bus.wr_data, 2)) & bus.pin_oe) == '0;
  endproperty
  a_drive: assert property (p_drive) else $error("written value not driven in output mode");

  property p_no_drive;
    @(posedge sys_clk) disable iff (reset)
    (bus.pin_oe & ~$past(out_mask)) == '0;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven outside output mode");

  property p_pull;
    @(posedge sys_clk) disable iff (reset)
    $stable(bus.mode) |=> bus.pull_en == $past(pu_mask);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up enable not following mode");

  property p_por_clear;
    @(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> latch_r == GCD_DATA_RST && bus.pull_en == '1;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("latch not cleared by power-on reset");
endmodule

// ### design/gcd_port_cd.sv
// Purpose: AXI4-Lite register front end for the port C and port D data registers
// Assumes: reset is the power-on reset; one write and one read in flight at most
// Notes: mode registers stand in for the pin-function controller's per-pin codes
`timescale 1ns/1ns
module gcd_port_cd
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [gcd_pkg::GCD_PORT_W-1:0] port_c_pin_i,
  output logic [gcd_pkg::GCD_PORT_W-1:0] port_c_pin_o,
  output logic [gcd_pkg::GCD_PORT_W-1:0] port_c_pin_oe,
  output logic [gcd_pkg::GCD_PORT_W-1:0] port_c_pull_en,
  input wire logic [gcd_pkg::GCD_PORT_W-1:0] port_d_pin_i,
  output logic [gcd_pkg::GCD_PORT_W-1:0] port_d_pin_o,
  output logic [gcd_pkg::GCD_PORT_W-1:0] port_d_pin_oe,
  output logic [gcd_pkg::GCD_PORT_W-1:0] port_d_pull_en
);
  import gcd_pkg::*;

  localparam int unsigned PW = GCD_PORT_W;
  localparam int unsigned MW = GCD_MODE_W;

  gcd_bank_if #(.W(PW)) c_if ();
  gcd_bank_if #(.W(PW)) d_if ();

  // write channel state
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  // read channel state
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  // per-pin mode codes, two bits a pin
  logic [MW-1:0] mode_c_r;
  logic [MW-1:0] mode_d_r;
  logic [MW-1:0] mode_c_nxt;
  logic [MW-1:0] mode_d_nxt;

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
    hit = (addr == gcd_byte_addr(idx));
  endfunction

  function automatic logic [MW-1:0] mode_merge(input logic [MW-1:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
    logic [MW-1:0] m;
    m = old;
    for (int b = 0; b < MW / 8; b++)
    begin
      if (strb[b])
      begin
        m[8*b +: 8] = data[8*b +: 8];
      end
    end
    mode_merge = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  wire aw_fire = s_axi_awvalid && awready_r;
  wire w_fire = s_axi_wvalid && wready_r;
  wire b_fire = bvalid_r && s_axi_bready;
  // both halves held and no answer pending: perform the write this cycle
  wire wr_go = !awready_r && !wready_r && !bvalid_r;
  wire wr_hit_c = hit(awaddr_r, GCD_PORT_C_IDX);
  wire wr_hit_d = hit(awaddr_r, GCD_PORT_D_IDX);
  wire wr_hit_mc = hit(awaddr_r, GCD_MODE_C_IDX);
  wire wr_hit_md = hit(awaddr_r, GCD_MODE_D_IDX);
  wire wr_hit = wr_hit_c || wr_hit_d || wr_hit_mc || wr_hit_md;

  // data registers hold one byte; only lane 0 reaches them
  assign c_if.wr_en = wr_go && wr_hit_c && wstrb_r[0];
  assign d_if.wr_en = wr_go && wr_hit_d && wstrb_r[0];
  assign c_if.wr_data = wdata_r[PW-1:0];
  assign d_if.wr_data = wdata_r[PW-1:0];
  assign mode_c_nxt = (wr_go && wr_hit_mc) ? mode_merge(mode_c_r, wdata_r, wstrb_r) : mode_c_r;
  assign mode_d_nxt = (wr_go && wr_hit_md) ? mode_merge(mode_d_r, wdata_r, wstrb_r) : mode_d_r;
  assign c_if.mode = mode_c_r;
  assign d_if.mode = mode_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // read decode
  wire ar_fire = s_axi_arvalid && arready_r;
  wire r_fire = rvalid_r && s_axi_rready;
  wire rd_hit_c = hit(s_axi_araddr, GCD_PORT_C_IDX);
  wire rd_hit_d = hit(s_axi_araddr, GCD_PORT_D_IDX);
  wire rd_hit_mc = hit(s_axi_araddr, GCD_MODE_C_IDX);
  wire rd_hit_md = hit(s_axi_araddr, GCD_MODE_D_IDX);
  wire rd_hit = rd_hit_c || rd_hit_d || rd_hit_mc || rd_hit_md;
  // upper bits read as zero
  wire [31:0] rd_word = ({32{rd_hit_c}} & {{(32-PW){1'b0}}, c_if.rd_data})
                      | ({32{rd_hit_d}} & {{(32-PW){1'b0}}, d_if.rd_data})
                      | ({32{rd_hit_mc}} & {{(32-MW){1'b0}}, mode_c_r})
                      | ({32{rd_hit_md}} & {{(32-MW){1'b0}}, mode_d_r});

  ////////////////////////////////////////////////////////////////////////////
  // write address and data are taken in either order, response follows both
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= GCD_RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else
    begin
      if (aw_fire)
      begin
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? GCD_RESP_OKAY : GCD_RESP_SLVERR;
      end
      if (b_fire)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= GCD_RESP_OKAY;
      rdata_r <= '0;
    end
    else if (ar_fire)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? GCD_RESP_OKAY : GCD_RESP_SLVERR;
      rdata_r <= rd_word;
    end
    else if (r_fire)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // pins come up as inputs with pull-up after power-on reset
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mode_c_r <= GCD_MODE_RST;
      mode_d_r <= GCD_MODE_RST;
    end
    else
    begin
      mode_c_r <= mode_c_nxt;
      mode_d_r <= mode_d_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  gcd_pin_bank #(.W(PW), .RW_MASK(GCD_PORT_C_RW)) u_bank_c
  (
    .sys_clk (sys_clk),
    .reset (reset),
    .pin_i (port_c_pin_i),
    .bus (c_if.bank)
  );

  // bits 6 and 4 are input-only pins
  gcd_pin_bank #(.W(PW), .RW_MASK(GCD_PORT_D_RW)) u_bank_d
  (
    .sys_clk (sys_clk),
    .reset (reset),
    .pin_i (port_d_pin_i),
    .bus (d_if.bank)
  );

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign port_c_pin_o = c_if.pin_o;
  assign port_c_pin_oe = c_if.pin_oe;
  assign port_c_pull_en = c_if.pull_en;
  assign port_d_pin_o = d_if.pin_o;
  assign port_d_pin_oe = d_if.pin_oe;
  assign port_d_pull_en = d_if.pull_en;

  ////////////////////////////////////////////////////////////////////////////
  property p_write_answer;
    @(posedge sys_clk) disable iff (reset)
    wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response missing after both halves");

  property p_read_answer;
    @(posedge sys_clk) disable iff (reset)
    ar_fire && rd_hit_c |=> s_axi_rvalid && s_axi_rdata[31:PW] == '0 && s_axi_rresp == GCD_RESP_OKAY;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("port data read not answered as a byte");

  property p_d_write_mask;
    @(posedge sys_clk) disable iff (reset)
    ar_fire && rd_hit_d && mode_d_r == '0 |=> (s_axi_rdata[PW-1:0] & ~GCD_PORT_D_RW) == '0;
  endproperty
  a_d_write_mask: assert property (p_d_write_mask) else $error("port D input-only bits read nonzero");

  property p_por_modes;
    @(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> mode_c_r == GCD_MODE_RST && mode_d_r == GCD_MODE_RST;
  endproperty
  a_por_modes: assert property (p_por_modes) else $error("pins not input with pull-up after reset");

  property p_aw_take;
    @(posedge sys_clk) disable iff (reset)
    aw_fire && w_fire
      |=> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_take: assert property (p_aw_take) else $error("write channels open after take");

  property p_b_time;
    @(posedge sys_clk) disable iff (reset)
    aw_fire && w_fire
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response not two cycles after take");

  property p_aw_stall;
    @(posedge sys_clk) disable iff (reset)
    s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_stall: assert property (p_aw_stall) else $error("write taken while response pending");

  property p_ar_stall;
    @(posedge sys_clk) disable iff (reset)
    s_axi_rvalid
      |-> !s_axi_arready;
  endproperty
  a_ar_stall: assert property (p_ar_stall) else $error("read taken while data pending");

  property p_b_release;
    @(posedge sys_clk) disable iff (reset)
    b_fire
      |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_release: assert property (p_b_release) else $error("write side not idle after response");

  property p_r_release;
    @(posedge sys_clk) disable iff (reset)
    r_fire
      |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_release: assert property (p_r_release) else $error("read side not idle after data");

  property p_r_answer;
    @(posedge sys_clk) disable iff (reset)
    ar_fire
      |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read data not one cycle after take");

  property p_bad_write;
    @(posedge sys_clk) disable iff (reset)
    wr_go && !wr_hit
      |=> s_axi_bresp == GCD_RESP_SLVERR;
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("unmapped write not refused");

  property p_bad_read;
    @(posedge sys_clk) disable iff (reset)
    ar_fire && !rd_hit
      |=> s_axi_rresp == GCD_RESP_SLVERR && s_axi_rdata == '0;
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");

  property p_d_byte;
    @(posedge sys_clk) disable iff (reset)
    ar_fire && rd_hit_d
      |=> s_axi_rdata[31:PW] == '0 && s_axi_rresp == GCD_RESP_OKAY;
  endproperty
  a_d_byte: assert property (p_d_byte) else $error("port D read not answered as a byte");

  property p_mode_hold;
    @(posedge sys_clk) disable iff (reset)
    !(wr_go && (wr_hit_mc || wr_hit_md))
      |=> $stable(mode_c_r) && $stable(mode_d_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode codes changed without a write");

  property p_ro_undriven;
    @(posedge sys_clk) disable iff (reset)
    (port_d_pin_oe & ~GCD_PORT_D_RW) == '0
      && (port_c_pin_oe & ~GCD_PORT_C_RW) == '0;
  endproperty
  a_ro_undriven: assert property (p_ro_undriven) else $error("input-only pin driven");

  property p_reset_idle;
    @(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> s_axi_awready && s_axi_wready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid && port_c_pin_oe == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bus or pins not idle after reset");
endmodule

// ### tb/gcd_pin_model.sv
// Purpose: external pin wiring for one port, seen from the board side
// Assumes: device drive wins over board drive; pull-up only while undriven
// Notes: a floating pin with no pull-up toggles every cycle, never holds
`timescale 1ns/1ns
module gcd_pin_model
(
  input wire logic sys_clk,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_en,
  output logic [7:0] pin_i
);
  logic [7:0] float_r = 8'h00;
  always @(posedge sys_clk) float_r <= ~float_r;
  ////////////////////////////////////////////////////////////
  // per-bit wire resolution; the pull-up holds an undriven line high
  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      if (pin_oe[k])
        pin_i[k] = pin_o[k];
      else if (ext_en[k])
        pin_i[k] = ext_val[k];
      else if (pull_en[k])
        pin_i[k] = 1'b1;
      else
        pin_i[k] = float_r[k];
    end
  end
endmodule

// ### tb/tb.sv
// Purpose: register-level bench for the port C / port D data block
// Assumes: AXI4-Lite master tasks, one access at a time
// Notes: pin reads are taken only after the input synchronisers settle
`timescale 1ns/1ns
module tb;
  import gcd_pkg::*;
  localparam logic [31:0] A_C = {GCD_PORT_C_IDX[29:0], 2'b00};
  localparam logic [31:0] A_D = {GCD_PORT_D_IDX[29:0], 2'b00};
  localparam logic [31:0] A_MC = {GCD_MODE_C_IDX[29:0], 2'b00};
  localparam logic [31:0] A_MD = {GCD_MODE_D_IDX[29:0], 2'b00};
  localparam logic [31:0] A_BAD = 32'h1000_0600;
  logic sys_clk, reset;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [7:0] c_in, c_o, c_oe, c_pu, d_in, d_o, d_oe, d_pu, c_ext, c_en, d_ext, d_en;
  int n_errors = 0;
  int n_compared = 0;

  gcd_port_cd dut (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .port_c_pin_i(c_in), .port_c_pin_o(c_o), .port_c_pin_oe(c_oe),
    .port_c_pull_en(c_pu), .port_d_pin_i(d_in), .port_d_pin_o(d_o), .port_d_pin_oe(d_oe),
    .port_d_pull_en(d_pu));
  gcd_pin_model pins_c (.sys_clk(sys_clk), .ext_val(c_ext), .ext_en(c_en), .pin_o(c_o),
    .pin_oe(c_oe), .pull_en(c_pu), .pin_i(c_in));
  gcd_pin_model pins_d (.sys_clk(sys_clk), .ext_val(d_ext), .ext_en(d_en), .pin_o(d_o),
    .pin_oe(d_oe), .pull_en(d_pu), .pin_i(d_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // single word accesses only; no bursts, nothing cached
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge sys_clk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp_resp("bresp", er, bresp);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp_reg("rdata", e, rdata);
    cmp_resp("rresp", er, rresp);
  endtask

  // output registers lag a cycle, inputs pass two sync flops
  task automatic settle;
    repeat (4) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end

  initial
  begin
    reset = 1'b1;
    {awaddr, wdata, araddr, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {c_ext, c_en, d_ext, d_en} = '0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    settle();
    cmp_pin("c_pull", 8'hFF, c_pu);
    cmp_pin("c_oe", 8'h00, c_oe);
    cmp_pin("d_pull", 8'hFF, d_pu);
    rd(A_MC, 32'h0000_AAAA, GCD_RESP_OKAY);
    rd(A_MD, 32'h0000_AAAA, GCD_RESP_OKAY);
    rd(A_C, 32'h0000_00FF, GCD_RESP_OKAY);
    rd(A_D, 32'h0000_00FF, GCD_RESP_OKAY);
    wr(A_MC, 32'h0000_0000, 4'h3, GCD_RESP_OKAY);
    wr(A_MD, 32'h0000_0000, 4'h3, GCD_RESP_OKAY);
    rd(A_C, 32'h0000_0000, GCD_RESP_OKAY);
    rd(A_D, 32'h0000_0000, GCD_RESP_OKAY);
    $display("test reset values done");
    wr(A_MC, 32'h0000_5555, 4'h3, GCD_RESP_OKAY);
    wr(A_C, 32'h0000_00A5, 4'h1, GCD_RESP_OKAY);
    settle();
    cmp_pin("c_pin_o", 8'hA5, c_o);
    cmp_pin("c_oe", 8'hFF, c_oe);
    cmp_pin("c_pull", 8'h00, c_pu);
    rd(A_C, 32'h0000_00A5, GCD_RESP_OKAY);
    wr(A_MC, 32'h0000_0000, 4'h3, GCD_RESP_OKAY);
    wr(A_C, 32'h0000_003C, 4'h1, GCD_RESP_OKAY);
    settle();
    cmp_pin("c_oe", 8'h00, c_oe);
    rd(A_C, 32'h0000_003C, GCD_RESP_OKAY);
    $display("test output and alternate done");
    c_en <= 8'hFF;
    c_ext <= 8'h96;
    wr(A_MC, 32'h0000_FFFF, 4'h3, GCD_RESP_OKAY);
    wr(A_C, 32'h0000_0011, 4'h1, GCD_RESP_OKAY);
    settle();
    cmp_pin("c_pull", 8'h00, c_pu);
    cmp_pin("c_oe", 8'h00, c_oe);
    rd(A_C, 32'h0000_0096, GCD_RESP_OKAY);
    // pins 0,4 alternate; 1,5 output; 2,6 input pull-up; 3,7 input plain
    wr(A_MC, 32'h0000_E4E4, 4'h3, GCD_RESP_OKAY);
    settle();
    rd(A_C, 32'h0000_0095, GCD_RESP_OKAY);
    cmp_pin("c_oe", 8'h22, c_oe);
    cmp_pin("c_pull", 8'h44, c_pu);
    $display("test mixed modes done");
    wr(A_MD, 32'h0000_5555, 4'h3, GCD_RESP_OKAY);
    wr(A_D, 32'h0000_00FF, 4'h1, GCD_RESP_OKAY);
    settle();
    cmp_pin("d_oe", 8'hAF, d_oe);
    cmp_pin("d_pin_o", 8'hAF, d_o & 8'hAF);
    rd(A_D, 32'h0000_00AF, GCD_RESP_OKAY);
    d_en <= 8'hFF;
    d_ext <= 8'h00;
    wr(A_MD, 32'h0000_AAAA, 4'h3, GCD_RESP_OKAY);
    settle();
    rd(A_D, 32'h0000_0000, GCD_RESP_OKAY);
    d_ext <= 8'h50;
    settle();
    rd(A_D, 32'h0000_0050, GCD_RESP_OKAY);
    wr(A_MD, 32'h0000_FFFF, 4'h3, GCD_RESP_OKAY);
    settle();
    cmp_pin("d_pull", 8'h00, d_pu);
    rd(A_D, 32'h0000_0050, GCD_RESP_OKAY);
    wr(A_MD, 32'h0000_0000, 4'h3, GCD_RESP_OKAY);
    rd(A_D, 32'h0000_00AF, GCD_RESP_OKAY);
    $display("test port d done");
    wr(A_MC, 32'h0000_0000, 4'h3, GCD_RESP_OKAY);
    wr(A_C, 32'h0000_0000, 4'h0, GCD_RESP_OKAY);
    rd(A_C, 32'h0000_0011, GCD_RESP_OKAY);
    wr(A_BAD, 32'h0000_00FF, 4'hF, GCD_RESP_SLVERR);
    rd(A_BAD, 32'h0000_0000, GCD_RESP_SLVERR);
    rd(A_C, 32'h0000_0011, GCD_RESP_OKAY);
    $display("test refusals done");
    // a second power-on reset must clear latches that now hold ones
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(A_MD, 32'h0000_AAAA, GCD_RESP_OKAY);
    wr(A_MC, 32'h0000_0000, 4'h3, GCD_RESP_OKAY);
    wr(A_MD, 32'h0000_0000, 4'h3, GCD_RESP_OKAY);
    rd(A_C, 32'h0000_0000, GCD_RESP_OKAY);
    rd(A_D, 32'h0000_0000, GCD_RESP_OKAY);
    $display("test second reset done");
    summarize();
  end
endmodule
